// ### hdl/trim_defs.vh
// Purpose: Shared constants for the channel trim register bank.
// Assumes: Included by bare name from every design file that needs it.
// Notes: Register indices are word indices; byte address is four times the index.
`ifndef TRIM_DEFS_VH
`define TRIM_DEFS_VH

// ==========================================================================
// Register word indices of both channels.
`define CH4_CONFIG_IDX 6'h1D
`define CH4_OFFSET_TRIM_HIGH_IDX 6'h1E
`define CH4_OFFSET_TRIM_LOW_IDX 6'h1F
`define CH4_GAIN_TRIM_HIGH_IDX 6'h20
`define CH4_GAIN_TRIM_LOW_IDX 6'h21
`define CH5_CONFIG_IDX 6'h22
`define CH5_OFFSET_TRIM_HIGH_IDX 6'h23
`define CH5_OFFSET_TRIM_LOW_IDX 6'h24
`define CH5_GAIN_TRIM_HIGH_IDX 6'h25
`define CH5_GAIN_TRIM_LOW_IDX 6'h26

// ==========================================================================
// Positions of the five registers inside one channel block.
`define SLOT_CONFIG 3'h0
`define SLOT_OFFSET_HIGH 3'h1
`define SLOT_OFFSET_LOW 3'h2
`define SLOT_GAIN_HIGH 3'h3
`define SLOT_GAIN_LOW 3'h4
`define SLOTS_PER_CHANNEL 6'h05

// ==========================================================================
// Field positions.
`define CFG_PHASE_MSB 15
`define CFG_PHASE_LSB 6
`define CFG_DC_OFF_BIT 2
`define CFG_SELECT_MSB 1
`define CFG_SELECT_LSB 0
`define LOW_FIELD_MSB 15
`define LOW_FIELD_LSB 8

// ==========================================================================
// Reset values.
`define GAIN_HIGH_RST 16'h8000
`define ZERO16_RST 16'h0000
`define ZERO8_RST 8'h00
`define PHASE_RST 10'h000
`define SELECT_RST 2'h0

// ==========================================================================
// Input select codes.
`define SEL_EXTERNAL 2'h0
`define SEL_SHORTED 2'h1
`define SEL_TEST_POS 2'h2
`define SEL_TEST_NEG 2'h3

// ==========================================================================
// Bus encodings.
`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD 3'h2
`define HRESP_OKAY 1'h0

`endif

// ### hdl/channel_trim_regs.v
// Purpose: Holds the five trim and configuration registers of one channel.
// Assumes: Writes arrive as a one-hot slot strobe with 16-bit data.
// Notes: Reserved bits are not stored, so they always read as zero.
`timescale 1ns/10ps
`include "trim_defs.vh"

module channel_trim_regs (
    input wire clk,
    input wire arst_n,
    input wire ce,
    input wire [4:0] wr_slot,
    input wire [15:0] wdata,
    input wire [3:0] global_dc_filter_setting,
    output wire [15:0] cfg_word,
    output wire [15:0] off_hi_word,
    output wire [15:0] off_lo_word,
    output wire [15:0] gain_hi_word,
    output wire [15:0] gain_lo_word,
    output wire signed [23:0] offset_trim,
    output wire [23:0] gain_trim,
    output wire signed [9:0] phase_delay,
    output wire dc_filter_off,
    output wire dc_filter_active,
    output wire [1:0] input_select
);

    // Stored fields; reserved bits have no storage at all.
    reg [9:0] phase_q; // Phase delay field.
    reg dc_off_q; // Per-channel filter disable.
    reg [1:0] sel_q; // Input selector.
    reg [15:0] off_hi_q; // Offset trim bits 23:8.
    reg [7:0] off_lo_q; // Offset trim bits 7:0.
    reg [15:0] gain_hi_q; // Gain trim bits 23:8.
    reg [7:0] gain_lo_q; // Gain trim bits 7:0.
    reg dc_act_q; // Effective filter enable.

    // ======================================================================
    // Register writes
    // Each slot takes only its writable bits, so reserved bits stay zero.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_q <= `PHASE_RST;
            dc_off_q <= 1'b0;
            sel_q <= `SELECT_RST;
            off_hi_q <= `ZERO16_RST;
            off_lo_q <= `ZERO8_RST;
            gain_hi_q <= `GAIN_HIGH_RST;
            gain_lo_q <= `ZERO8_RST;
        end else if (ce) begin
            if (wr_slot[`SLOT_CONFIG]) begin
                phase_q <= wdata[`CFG_PHASE_MSB:`CFG_PHASE_LSB];
                dc_off_q <= wdata[`CFG_DC_OFF_BIT];
                sel_q <= wdata[`CFG_SELECT_MSB:`CFG_SELECT_LSB];
            end
            if (wr_slot[`SLOT_OFFSET_HIGH]) begin
                off_hi_q <= wdata;
            end
            if (wr_slot[`SLOT_OFFSET_LOW]) begin
                off_lo_q <= wdata[`LOW_FIELD_MSB:`LOW_FIELD_LSB];
            end
            if (wr_slot[`SLOT_GAIN_HIGH]) begin
                gain_hi_q <= wdata;
            end
            if (wr_slot[`SLOT_GAIN_LOW]) begin
                gain_lo_q <= wdata[`LOW_FIELD_MSB:`LOW_FIELD_LSB];
            end
        end
    end

    // ======================================================================
    // Filter enable
    // The channel bit forces the filter off; otherwise the global setting,
    // where a zero field means the global filter is off.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dc_act_q <= 1'b0;
        end else if (ce) begin
            dc_act_q <= ~dc_off_q & (|global_dc_filter_setting);
        end
    end

    // Read words with reserved fields forced to zero.
    assign cfg_word = {phase_q, 3'h0, dc_off_q, sel_q};
    assign off_hi_word = off_hi_q;
    assign off_lo_word = {off_lo_q, 8'h00};
    assign gain_hi_word = gain_hi_q;
    assign gain_lo_word = {gain_lo_q, 8'h00};

    // Assembled values; offset and phase are two's complement.
    assign offset_trim = {off_hi_q, off_lo_q};
    // Gain is an unsigned fraction: value / 2**23, so 0x800000 is unity.
    assign gain_trim = {gain_hi_q, gain_lo_q};
    assign phase_delay = phase_q;
    assign dc_filter_off = dc_off_q;
    assign dc_filter_active = dc_act_q;
    assign input_select = sel_q;

endmodule // channel_trim_regs

// ### hdl/adc_channel_trim_registers.v
// Purpose: AHB-Lite register bank for the trim and configuration of
//          converter channels 4 and 5.
// Assumes: One AHB-Lite master, single word transfers, one clock domain.
// Notes: Writes take no wait state; reads take one wait state.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/10ps
`include "trim_defs.vh"

module adc_channel_trim_registers (
    input wire clk,
    input wire arst_n,
    input wire ce,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire [3:0] global_dc_filter_setting,
    output wire signed [23:0] ch4_offset_trim,
    output wire [23:0] ch4_gain_trim,
    output wire signed [9:0] ch4_phase_delay,
    output wire ch4_dc_filter_off,
    output wire ch4_dc_filter_active,
    output wire [1:0] ch4_input_select,
    output wire signed [23:0] ch5_offset_trim,
    output wire [23:0] ch5_gain_trim,
    output wire signed [9:0] ch5_phase_delay,
    output wire ch5_dc_filter_off,
    output wire ch5_dc_filter_active,
    output wire [1:0] ch5_input_select
);

    // Number of channel blocks held here.
    localparam integer NUM_CH = 2;

    // ======================================================================
    // Bus state
    reg wr_pend_q; // A write is in its data phase.
    reg rd_pend_q; // A read is in its data phase.
    reg [5:0] idx_q; // Word index of the pending transfer.
    reg word_q; // The pending transfer is a whole word below byte address 0x100.
    reg ready_q; // Drives hreadyout.
    reg [31:0] rdata_q; // Drives hrdata.
    reg resp_q; // Drives hresp.

    // Address phase accepted this cycle.
    wire accept;
    // Read value selected for the pending index.
    reg [15:0] rd_word;

    // Per-channel wiring, flattened by channel number.
    wire [NUM_CH*5-1:0] wr_slot_all; // Write strobes, five per channel.
    wire [NUM_CH*80-1:0] words_all; // Five read words per channel.
    wire [NUM_CH-1:0] hit_all; // Pending index falls in the channel.
    wire [NUM_CH*3-1:0] slot_all; // Slot number inside the channel.
    wire [NUM_CH*24-1:0] offset_all; // Assembled offset trims.
    wire [NUM_CH*24-1:0] gain_all; // Assembled gain trims.
    wire [NUM_CH*10-1:0] phase_all; // Phase delays.
    wire [NUM_CH-1:0] dc_off_all; // Channel filter disables.
    wire [NUM_CH-1:0] dc_act_all; // Effective filter enables.
    wire [NUM_CH*2-1:0] sel_all; // Input selectors.

    // A transfer is taken only when selected, non-idle and the bus is ready.
    assign accept = ce & hsel & hready & htrans[1];

    // ======================================================================
    // Transfer tracking
    // A write opens a one-cycle data phase; a read drops hreadyout for one
    // cycle so the read word is sampled after any earlier write commits.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            idx_q <= 6'h00;
            word_q <= 1'b0;
            ready_q <= 1'b1;
            resp_q <= `HRESP_OKAY;
        end else if (ce) begin
            wr_pend_q <= accept & hwrite;
            rd_pend_q <= accept & ~hwrite;
            // Response is always OKAY, even for unmapped addresses.
            resp_q <= `HRESP_OKAY;
            if (accept) begin
                // Byte address to word index.
                idx_q <= haddr[7:2];
                word_q <= (hsize == `HSIZE_WORD) & (haddr[31:8] == 24'h000000);
                // Insert the single wait state of a read.
                ready_q <= hwrite;
            end else begin
                // Release the wait state after the read word is loaded.
                ready_q <= 1'b1;
            end
        end
    end

    // ======================================================================
    // Channel blocks
    // Each channel decodes its own five-word window from its base index.
    genvar c;
    generate
        for (c = 0; c < NUM_CH; c = c + 1) begin : g_ch
            // Base index of this channel's configuration word.
            wire [5:0] base = (c == 0) ? `CH4_CONFIG_IDX : `CH5_CONFIG_IDX;
            // Distance of the pending index from the base.
            wire [5:0] rel = idx_q - base;
            // The index lies inside this channel's five words.
            assign hit_all[c] = word_q & (idx_q >= base) &
                                (rel < `SLOTS_PER_CHANNEL);
            assign slot_all[c*3 +: 3] = rel[2:0];
            // One-hot write strobe for the addressed slot.
            assign wr_slot_all[c*5 +: 5] = (wr_pend_q & hit_all[c]) ?
                                           (5'h01 << rel[2:0]) : 5'h00;

            channel_trim_regs u_regs (
                .clk(clk),
                .arst_n(arst_n),
                .ce(ce),
                .wr_slot(wr_slot_all[c*5 +: 5]),
                .wdata(hwdata[15:0]),
                .global_dc_filter_setting(global_dc_filter_setting),
                .cfg_word(words_all[c*80 +: 16]),
                .off_hi_word(words_all[c*80+16 +: 16]),
                .off_lo_word(words_all[c*80+32 +: 16]),
                .gain_hi_word(words_all[c*80+48 +: 16]),
                .gain_lo_word(words_all[c*80+64 +: 16]),
                .offset_trim(offset_all[c*24 +: 24]),
                .gain_trim(gain_all[c*24 +: 24]),
                .phase_delay(phase_all[c*10 +: 10]),
                .dc_filter_off(dc_off_all[c]),
                .dc_filter_active(dc_act_all[c]),
                .input_select(sel_all[c*2 +: 2])
            );
        end
    endgenerate

    // ======================================================================
    // Read selection
    // Picks the word of the hit channel; unmapped indices give zero.
    always @* begin
        rd_word = 16'h0000;
        if (hit_all[0]) begin
            case (slot_all[2:0])
                `SLOT_CONFIG: rd_word = words_all[15:0];
                `SLOT_OFFSET_HIGH: rd_word = words_all[31:16];
                `SLOT_OFFSET_LOW: rd_word = words_all[47:32];
                `SLOT_GAIN_HIGH: rd_word = words_all[63:48];
                `SLOT_GAIN_LOW: rd_word = words_all[79:64];
                default: rd_word = 16'h0000;
            endcase
        end else if (hit_all[1]) begin
            case (slot_all[5:3])
                `SLOT_CONFIG: rd_word = words_all[95:80];
                `SLOT_OFFSET_HIGH: rd_word = words_all[111:96];
                `SLOT_OFFSET_LOW: rd_word = words_all[127:112];
                `SLOT_GAIN_HIGH: rd_word = words_all[143:128];
                `SLOT_GAIN_LOW: rd_word = words_all[159:144];
                default: rd_word = 16'h0000;
            endcase
        end
    end

    // ======================================================================
    // Read data register
    // Loaded in the wait-state cycle of a read; upper half always zero.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 32'h00000000;
        end else if (ce) begin
            if (rd_pend_q) begin
                rdata_q <= {16'h0000, rd_word};
            end
        end
    end

    // ======================================================================
    // Outputs
    // Every output is a flip-flop of this block or of a channel block.
    assign hrdata = rdata_q;
    assign hreadyout = ready_q;
    assign hresp = resp_q;

    assign ch4_offset_trim = offset_all[23:0];
    assign ch4_gain_trim = gain_all[23:0];
    assign ch4_phase_delay = phase_all[9:0];
    assign ch4_dc_filter_off = dc_off_all[0];
    assign ch4_dc_filter_active = dc_act_all[0];
    assign ch4_input_select = sel_all[1:0];

    assign ch5_offset_trim = offset_all[47:24];
    assign ch5_gain_trim = gain_all[47:24];
    assign ch5_phase_delay = phase_all[19:10];
    assign ch5_dc_filter_off = dc_off_all[1];
    assign ch5_dc_filter_active = dc_act_all[1];
    assign ch5_input_select = sel_all[3:2];

endmodule // adc_channel_trim_registers

// ### test/trim_checker.sv
// Purpose: Concurrent checks on the trim register bank ports.
// Assumes: Bound to the bank top; one clock domain; byte address = 4 * index.
// Notes: Data phase follows the address phase by one cycle.
`timescale 1ns/10ps

// ==========================================================================
// Checker module.
module trim_checker (
    input wire clk,
    input wire arst_n,
    input wire ce,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire [3:0] global_dc_filter_setting,
    input wire signed [23:0] ch4_offset_trim,
    input wire [23:0] ch4_gain_trim,
    input wire signed [9:0] ch4_phase_delay,
    input wire ch4_dc_filter_off,
    input wire [1:0] ch4_input_select,
    input wire signed [23:0] ch5_offset_trim,
    input wire [23:0] ch5_gain_trim,
    input wire signed [9:0] ch5_phase_delay,
    input wire ch5_dc_filter_off,
    input wire ch5_dc_filter_active,
    input wire [1:0] ch5_input_select
);
    // High when a transfer is accepted at this edge.
    wire take = ce && hsel && hready && htrans[1];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_resp_always_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    a_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_no_wait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    a_rdata_upper_zero: assert property (hrdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    a_rdata_holds: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data changed while idle");
    a_trim_reset_vals: assert property ($rose(arst_n) |-> ch4_gain_trim == 24'h800000
        && ch5_gain_trim == 24'h800000 && ch4_offset_trim == 0 && ch5_offset_trim == 0)
        else $error("trim reset values wrong");
    a_dc_active_lag: assert property ($past(arst_n) |-> ch5_dc_filter_active ==
        $past(!ch5_dc_filter_off && global_dc_filter_setting != 4'h0))
        else $error("filter active flag wrong");
    a_cfg_write_lands: assert property (take && hwrite && haddr == 32'h88 && hsize == 3'h2
        ##1 1'b1 |=> ch5_phase_delay == $past(hwdata[15:6])
        && ch5_input_select == $past(hwdata[1:0]) && ch5_dc_filter_off == $past(hwdata[2]))
        else $error("config write not applied");
    a_offset_low_split: assert property (take && hwrite && haddr == 32'h7C && hsize == 3'h2
        ##1 1'b1 |=> ch4_offset_trim[7:0] == $past(hwdata[15:8])
        && $stable(ch4_offset_trim[23:8])) else $error("offset low byte misplaced");
    a_gain_high_split: assert property (take && hwrite && haddr == 32'h80 && hsize == 3'h2
        ##1 1'b1 |=> ch4_gain_trim[23:8] == $past(hwdata[15:0]) && $stable(ch4_gain_trim[7:0]))
        else $error("gain high word misplaced");
    a_refused_write: assert property (take && hwrite && (haddr[31:8] != 0 || hsize != 3'h2)
        ##1 1'b1 |=> $stable(ch4_phase_delay) && $stable(ch4_input_select)
        && $stable(ch4_dc_filter_off)) else $error("refused write changed config");
endmodule // trim_checker

bind adc_channel_trim_registers trim_checker i_chk (.clk(clk), .arst_n(arst_n), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .global_dc_filter_setting(global_dc_filter_setting), .ch4_offset_trim(ch4_offset_trim),
    .ch4_gain_trim(ch4_gain_trim), .ch4_phase_delay(ch4_phase_delay),
    .ch4_dc_filter_off(ch4_dc_filter_off), .ch4_input_select(ch4_input_select),
    .ch5_offset_trim(ch5_offset_trim), .ch5_gain_trim(ch5_gain_trim),
    .ch5_phase_delay(ch5_phase_delay), .ch5_dc_filter_off(ch5_dc_filter_off),
    .ch5_dc_filter_active(ch5_dc_filter_active), .ch5_input_select(ch5_input_select));

// ### test/testbench.sv
// Purpose: Directed bus tests of the trim register bank.
// Assumes: Tasks are entered just after a rising clock edge.
// Notes: Ready and read data are sampled at the rising edge, before the bank updates.
`timescale 1ns/10ps
`include "trim_defs.vh"

// ==========================================================================
// Testbench top.
module testbench;
    logic clk, arst_n, ce, hsel, hwrite;
    logic [31:0] haddr, hwdata, t;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] gdc;
    logic [15:0] wd [0:9];
    wire [31:0] hrdata;
    wire hreadyout, c5_off, c5_act, c4_off, c4_act, hresp;
    wire signed [9:0] c4_ph;
    wire [1:0] c4_sel;
    wire signed [23:0] c4_ofs, c5_ofs;
    wire [23:0] c4_gain, c5_gain;
    wire signed [9:0] c5_ph;
    wire [1:0] c5_sel;
    int err_count = 0;
    int checked = 0;

    adc_channel_trim_registers i_dut (.clk(clk), .arst_n(arst_n), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .global_dc_filter_setting(gdc), .ch4_offset_trim(c4_ofs), .ch4_gain_trim(c4_gain),
        .ch4_phase_delay(c4_ph), .ch4_dc_filter_off(c4_off), .ch4_dc_filter_active(c4_act),
        .ch4_input_select(c4_sel), .ch5_offset_trim(c5_ofs), .ch5_gain_trim(c5_gain),
        .ch5_phase_delay(c5_ph), .ch5_dc_filter_off(c5_off), .ch5_dc_filter_active(c5_act),
        .ch5_input_select(c5_sel));

    // Free-running 250 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Counts a comparison and reports a mismatch.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Waits for ready high at an edge, keeping the read data seen at that same edge.
    task automatic wait_rdy(output logic [31:0] d);
        logic ok;
        ok = 1'b0;
        while (!ok) begin
            @(posedge clk);
            ok = (hreadyout === 1'b1);
            d = hrdata;
        end
    endtask

    // One single transfer: address phase, then data phase.
    task automatic bus(input logic w, input logic [31:0] a, input logic [2:0] sz,
            input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        hsize <= sz;
        htrans <= `HTRANS_NONSEQ;
        wait_rdy(r);
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy(r);
    endtask

    // Word write and word read with compare.
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, `HSIZE_WORD, d, r);
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, `HSIZE_WORD, 32'h0, r);
        chk(r, e);
    endtask

    // Byte address of the k-th register counted from channel 4 config.
    function automatic logic [31:0] adr(input int k);
        return {24'h0, 6'(`CH4_CONFIG_IDX + k), 2'b00};
    endfunction

    // Storable bits of each slot; reserved bits read zero.
    function automatic logic [15:0] msk(input int s);
        return (s == 0) ? 16'hFFC7 : ((s == 2 || s == 4) ? 16'hFF00 : 16'hFFFF);
    endfunction

    // Prints the counts and the verdict, then stops.
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog; the tests need well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        print_verdict;
    end

    // Main test sequence.
    initial begin
        arst_n = 1'b0; ce = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
        hwrite = 1'b0; hsize = `HSIZE_WORD; hwdata = 32'h0; gdc = 4'h0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        for (int k = 0; k < 10; k++) rdc(adr(k), (k % 5 == 3) ? 32'h8000 : 32'h0);
        $display("test reset values done");
        for (int k = 0; k < 10; k++) begin
            wd[k] = {8'h91 + 8'(k * 13), 8'hFF};
            wr(adr(k), {16'hFFFF, wd[k]});
        end
        for (int k = 0; k < 10; k++) rdc(adr(k), {16'h0, wd[k] & msk(k % 5)});
        chk({8'h0, c4_ofs}, {8'h0, wd[1], wd[2][15:8]});
        chk({31'h0, c4_ofs < 0}, {31'h0, wd[1][15]});
        chk({8'h0, c4_gain}, {8'h0, wd[3], wd[4][15:8]});
        chk({8'h0, c5_ofs}, {8'h0, wd[6], wd[7][15:8]});
        chk({8'h0, c5_gain}, {8'h0, wd[8], wd[9][15:8]});
        chk({31'h0, c5_gain > 24'h800000}, 32'h1);
        chk({22'h0, c4_ph}, {22'h0, wd[0][15:6]});
        chk({31'h0, c4_off}, {31'h0, wd[0][2]});
        chk({31'h0, c4_act}, 32'h0);
        chk({30'h0, c4_sel}, {30'h0, wd[0][1:0]});
        chk({31'h0, hresp}, 32'h0);
        $display("test field layout done");
        for (int s = 0; s < 8; s++) begin
            gdc <= (s > 3) ? 4'h8 : 4'h0;
            wr(adr(5), {16'h0, 10'h200, 3'h7, s[0], s[1:0]});
            repeat (2) @(negedge clk);
            chk({30'h0, c5_sel}, 32'(s[1:0]));
            chk({31'h0, c5_off}, 32'(s[0]));
            chk({31'h0, c5_act}, 32'(!s[0] && s > 3));
            chk({31'h0, c5_ph < 0}, 32'h1);
            @(posedge clk);
        end
        $display("test config codes done");
        wr(32'h0000_0174, 32'h0000_FFFF);
        bus(1'b1, adr(0), 3'h0, 32'h0000_FFFF, t);
        wr(32'h9C, 32'hFFFF);
        rdc(adr(0), {16'h0, wd[0] & 16'hFFC7});
        rdc(32'h9C, 32'h0);
        rdc(32'h70, 32'h0);
        bus(1'b0, adr(3), 3'h0, 32'h0, t);
        chk(t, 32'h0);
        $display("test refused access done");
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rdc(adr(8), 32'h8000);
        rdc(adr(7), 32'h0);
        $display("test second reset done");
        print_verdict;
    end
endmodule // testbench
